/* rtl/oag_pkg.sv */
// Package: constants and enumerations for the operand address generator
package oag_pkg;
  // Addressing modes selected by the decoder
  typedef enum logic [3:0] {
    OAG_MODE_NONE     = 4'h0,
    OAG_MODE_IMPLIED  = 4'h1,
    OAG_MODE_REG      = 4'h2,
    OAG_MODE_DIRECT   = 4'h3,
    OAG_MODE_SHORT    = 4'h4,
    OAG_MODE_SFR      = 4'h5,
    OAG_MODE_REG_IND  = 4'h6,
    OAG_MODE_BASED    = 4'h7,
    OAG_MODE_BASED_IX = 4'h8,
    OAG_MODE_STACK    = 4'h9
  } oag_mode_t;

  // Implied-operand instruction classes
  typedef enum logic [2:0] {
    OAG_IMP_NONE = 3'h0,
    OAG_IMP_MUL  = 3'h1,
    OAG_IMP_DIV  = 3'h2,
    OAG_IMP_ADJ  = 3'h3,
    OAG_IMP_ROT  = 3'h4
  } oag_imp_t;

  // Stack operation kinds
  typedef enum logic [2:0] {
    OAG_STK_PUSH = 3'h0,
    OAG_STK_POP  = 3'h1,
    OAG_STK_CALL = 3'h2,
    OAG_STK_RET  = 3'h3,
    OAG_STK_INTR = 3'h4
  } oag_stk_t;

  // Register codes within a bank
  localparam logic [2:0] OAG_R_X = 3'h0;
  localparam logic [2:0] OAG_R_A = 3'h1;
  localparam logic [2:0] OAG_R_C = 3'h2;
  localparam logic [2:0] OAG_R_B = 3'h3;
  localparam logic [2:0] OAG_R_L = 3'h6;
  localparam logic [1:0] OAG_RP_AX = 2'h0;
  localparam logic [1:0] OAG_RP_DE = 2'h2;
  localparam logic [1:0] OAG_RP_HL = 2'h3;

  // Address map constants
  localparam logic [6:0] OAG_SHORT_HI7 = 7'h7F;
  localparam logic [7:0] OAG_SHORT_SPLIT = 8'h20;
  localparam logic [7:0] OAG_SFR_HI = 8'hFF;
  localparam logic [7:0] OAG_SFR_GAP_LO = 8'hD0;
  localparam logic [7:0] OAG_SFR_GAP_HI = 8'hDF;
  localparam logic [15:0] OAG_HSRAM_LO = 16'hFE20;
  localparam logic [15:0] OAG_HSRAM_HI = 16'hFEFF;
  localparam logic [15:0] OAG_SFR_BASE = 16'hFF00;
  localparam logic [15:0] OAG_SHORT_TOP = 16'hFF1F;
  localparam logic [7:0] OAG_ZERO8 = 8'h00;
endpackage

/* rtl/oag_reg_index.sv */
// Bank-relative register index builder
`timescale 1ns/1ps
module oag_reg_index (
  // Bank flags
  input wire logic i_bank_lo,
  input wire logic i_bank_hi,
  // Register code within the bank
  input wire logic [2:0] i_code,
  // Physical index 0..31
  output logic [4:0] o_index
);
  // Bank number forms the top two bits of the physical index
  assign o_index = {i_bank_hi, i_bank_lo, i_code};
endmodule

/* rtl/oag_add16.sv */
// Zero-extending 16-bit adder that drops the carry
`timescale 1ns/1ps
module oag_add16 (
  // Base and byte offset
  input wire logic [15:0] i_base,
  input wire logic [7:0] i_ofs,
  // Wrapped sum
  output logic [15:0] o_sum
);
  // Carry out of bit 15 is deliberately lost so the address wraps
  assign o_sum = i_base + {8'h00, i_ofs};
endmodule

/* rtl/oag_top.sv */
// Operand effective-address generator for the 8-bit core
`timescale 1ns/1ps
module oag_top
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Decoder request
  input wire logic i_valid,
  input wire oag_pkg::oag_mode_t i_mode,
  input wire oag_pkg::oag_imp_t i_imp,
  input wire oag_pkg::oag_stk_t i_stk,
  input wire logic i_word,
  input wire logic [2:0] i_reg_code,
  input wire logic i_index_c,
  input wire logic [7:0] i_imm8,
  input wire logic [15:0] i_imm16,
  // Bank select flags from the status word
  input wire logic i_bank_select_lo,
  input wire logic i_bank_select_hi,
  // Current bank register values
  input wire logic [7:0] i_reg_b,
  input wire logic [7:0] i_reg_c,
  input wire logic [15:0] i_pair_de,
  input wire logic [15:0] i_pair_hl,
  input wire logic [15:0] i_sp,
  // Register file operand selects
  output logic o_reg_valid,
  output logic [4:0] o_reg_src,
  output logic [4:0] o_reg_dst,
  output logic o_reg_dst_word,
  // Memory address
  output logic o_mem_valid,
  output logic [15:0] o_mem_addr,
  output logic o_mem_hsram,
  output logic o_mem_sfr,
  output logic o_mem_stack,
  // Misaligned or out-of-region access flag
  output logic o_addr_fault
);
  import oag_pkg::*;

  logic [2:0] next_src_code;
  logic [2:0] next_dst_code;
  logic next_dst_word;
  logic next_reg_valid;
  logic [4:0] src_index;
  logic [4:0] dst_index;
  logic [15:0] based_sum;
  logic [15:0] index_sum;
  logic [7:0] index_byte;
  logic [15:0] short_addr;
  logic [15:0] sfr_addr;
  logic [15:0] next_addr;
  logic next_mem_valid;
  logic next_fault;
  logic next_stack;

  // Bank-relative register selection for source and destination
  oag_reg_index u_src (
    .i_bank_lo(i_bank_select_lo),
    .i_bank_hi(i_bank_select_hi),
    .i_code(next_src_code),
    .o_index(src_index)
  );
  oag_reg_index u_dst (
    .i_bank_lo(i_bank_select_lo),
    .i_bank_hi(i_bank_select_hi),
    .i_code(next_dst_code),
    .o_index(dst_index)
  );

  // Based and based indexed sums each use their own instance of the wrapping adder
  assign index_byte = i_index_c ? i_reg_c : i_reg_b;
  oag_add16 u_based (
    .i_base(i_pair_hl),
    .i_ofs(i_imm8),
    .o_sum(based_sum)
  );
  oag_add16 u_index (
    .i_base(i_pair_hl),
    .i_ofs(index_byte),
    .o_sum(index_sum)
  );

  // Short direct: bit 8 inverted from the byte range, top seven bits ones
  assign short_addr = {OAG_SHORT_HI7, (i_imm8 < OAG_SHORT_SPLIT),
                       i_imm8};
  // SFR space: fixed upper byte
  assign sfr_addr = {OAG_SFR_HI, i_imm8};

  // Register operand selection, implied cases force the accumulator
  always_comb begin
    next_src_code = i_reg_code;
    next_dst_code = i_reg_code;
    next_dst_word = i_word;
    next_reg_valid = 1'b0;
    if (i_valid) begin
      unique case (i_mode)
        OAG_MODE_IMPLIED: begin
          next_reg_valid = 1'b1;
          unique case (i_imp)
            OAG_IMP_MUL: begin
              next_src_code = OAG_R_A;
              next_dst_code = {OAG_RP_AX, 1'b0};
              next_dst_word = 1'b1;
            end
            OAG_IMP_DIV: begin
              next_src_code = {OAG_RP_AX, 1'b0};
              next_dst_code = {OAG_RP_AX, 1'b0};
              next_dst_word = 1'b1;
            end
            OAG_IMP_ADJ: begin
              next_src_code = OAG_R_A;
              next_dst_code = OAG_R_A;
              next_dst_word = 1'b0;
            end
            OAG_IMP_ROT: begin
              next_src_code = OAG_R_A;
              next_dst_code = OAG_R_A;
              next_dst_word = 1'b0;
            end
            default: next_reg_valid = 1'b0;
          endcase
        end
        OAG_MODE_REG: begin
          next_reg_valid = 1'b1;
          // Pair number sits in the upper two code bits, low bit zero
          if (i_word) begin
            next_src_code = {i_reg_code[2:1], 1'b0};
            next_dst_code = {i_reg_code[2:1], 1'b0};
          end
        end
        default: next_reg_valid = 1'b0;
      endcase
    end
  end

  // Memory effective address per mode
  always_comb begin
    next_addr = OAG_SFR_BASE;
    next_mem_valid = 1'b0;
    next_fault = 1'b0;
    next_stack = 1'b0;
    if (i_valid) begin
      unique case (i_mode)
        OAG_MODE_DIRECT: begin
          next_addr = i_imm16;
          next_mem_valid = 1'b1;
        end
        OAG_MODE_SHORT: begin
          next_addr = short_addr;
          next_mem_valid = 1'b1;
          next_fault = i_word & i_imm8[0];
        end
        OAG_MODE_SFR: begin
          next_addr = sfr_addr;
          next_mem_valid = 1'b1;
          // Gap between the two SFR ranges raises the fault flag here
          next_fault = (i_imm8 >= OAG_SFR_GAP_LO &&
                        i_imm8 <= OAG_SFR_GAP_HI) |
                       (i_word & i_imm8[0]);
        end
        OAG_MODE_REG_IND: begin
          // Code bit 0 picks HL, otherwise DE
          next_addr = i_reg_code[0] ? i_pair_hl : i_pair_de;
          next_mem_valid = 1'b1;
        end
        OAG_MODE_BASED: begin
          next_addr = based_sum;
          next_mem_valid = 1'b1;
        end
        OAG_MODE_BASED_IX: begin
          next_addr = index_sum;
          next_mem_valid = 1'b1;
        end
        OAG_MODE_STACK: begin
          // Push, call and interrupt save address the top below SP;
          // pop and return read at SP itself
          unique case (i_stk)
            OAG_STK_POP, OAG_STK_RET: next_addr = i_sp;
            default: next_addr = i_sp - 16'h0001;
          endcase
          next_mem_valid = 1'b1;
          next_stack = 1'b1;
          // Software owns the SP range; hardware only flags a stray one
          next_fault = (next_addr < OAG_HSRAM_LO) ||
                       (next_addr > OAG_HSRAM_HI);
        end
        default: next_mem_valid = 1'b0;
      endcase
    end
  end

  // Register-file outputs, registered to give the decoder one stage
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_reg_valid <= 1'b0;
      o_reg_src <= 5'h00;
      o_reg_dst <= 5'h00;
      o_reg_dst_word <= 1'b0;
    end else begin
      o_reg_valid <= next_reg_valid;
      o_reg_src <= src_index;
      o_reg_dst <= dst_index;
      o_reg_dst_word <= next_dst_word;
    end
  end

  // Memory address outputs
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_mem_valid <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_hsram <= 1'b0;
      o_mem_sfr <= 1'b0;
      o_mem_stack <= 1'b0;
      o_addr_fault <= 1'b0;
    end else begin
      o_mem_valid <= next_mem_valid;
      o_mem_addr <= next_addr;
      o_mem_hsram <= next_mem_valid && next_addr >= OAG_HSRAM_LO &&
                     next_addr <= OAG_HSRAM_HI;
      o_mem_sfr <= next_mem_valid && next_addr >= OAG_SFR_BASE;
      o_mem_stack <= next_stack;
      o_addr_fault <= next_fault;
    end
  end

  // Short direct result always lies in the fixed window
  AST_SHORT_WINDOW: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_SHORT) |=>
    (o_mem_addr >= OAG_HSRAM_LO && o_mem_addr <= OAG_SHORT_TOP))
    else $error("short direct address outside window");

  AST_SHORT_BIT8: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_SHORT) |=>
    (o_mem_addr[8] == ($past(i_imm8) < OAG_SHORT_SPLIT)))
    else $error("short direct bit 8 wrong");

  AST_SHORT_LOW: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_SHORT) |=>
    (o_mem_addr[7:0] == $past(i_imm8) && o_mem_addr[15:9] == OAG_SHORT_HI7))
    else $error("short direct address bits wrong");

  AST_DIRECT: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_DIRECT) |=>
    (o_mem_valid && o_mem_addr == $past(i_imm16)))
    else $error("direct address wrong");

  AST_SFR_HI: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_SFR) |=>
    (o_mem_addr[15:8] == OAG_SFR_HI && o_mem_sfr))
    else $error("sfr upper byte wrong");

  AST_BASED: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_BASED) |=>
    (o_mem_addr == 16'($past(i_pair_hl) + {OAG_ZERO8, $past(i_imm8)})))
    else $error("based address wrong");

  // Index byte comes from B or C of the bank, carry out is dropped
  AST_BASED_IX: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_BASED_IX) |=>
    (o_mem_addr == 16'($past(i_pair_hl) +
                       {OAG_ZERO8, $past(i_index_c ? i_reg_c : i_reg_b)})))
    else $error("based indexed address wrong");

  AST_IND: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_REG_IND) |=>
    (o_mem_addr == ($past(i_reg_code[0]) ? $past(i_pair_hl)
                                          : $past(i_pair_de))))
    else $error("indirect address wrong");

  // Every stack request reaches memory marked as a stack access
  AST_STACK: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_STACK) |=>
    (o_mem_valid && o_mem_stack))
    else $error("stack access not flagged");

  // A stack address outside the RAM must raise the fault, and only then
  AST_STACK_RAM: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_STACK) |=>
    (o_addr_fault == !o_mem_hsram))
    else $error("stack region flag wrong");

  AST_MUL_A: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_IMPLIED && i_imp == OAG_IMP_MUL) |=>
    (o_reg_src[2:0] == OAG_R_A && o_reg_dst_word &&
     o_reg_src[4:3] == $past({i_bank_select_hi, i_bank_select_lo})))
    else $error("multiply implied operand wrong");

  AST_BANK: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_valid && i_mode == OAG_MODE_REG && !i_word) |=>
    (o_reg_src == $past({i_bank_select_hi, i_bank_select_lo, i_reg_code})))
    else $error("bank register index wrong");
endmodule

/* sim/oag_regfile_model.sv */
// Far-side model: current-bank register file contents and stack pointer
`timescale 1ns/1ps
module oag_regfile_model (
  // Bank flags
  input wire logic i_bank_lo,
  input wire logic i_bank_hi,
  // Test hook: drops the stack pointer to the bottom of the RAM
  input wire logic i_sp_low,
  // Current bank contents
  output logic [7:0] o_reg_b,
  output logic [7:0] o_reg_c,
  output logic [15:0] o_pair_de,
  output logic [15:0] o_pair_hl,
  output logic [15:0] o_sp
);
  logic [1:0] bank;
  assign bank = {i_bank_hi, i_bank_lo};
  // Every bank holds its own values, so a wrong bank is visible
  assign o_reg_b = 8'h20 + {6'h00, bank};
  assign o_reg_c = 8'h40 + {6'h00, bank};
  assign o_pair_de = 16'hA000 + {14'h0000, bank};
  // Bank 0 sits near the top so offsets wrap past FFFFH
  assign o_pair_hl = (bank == 2'h0) ? 16'hFFF0 :
                     16'h1230 + {14'h0000, bank};
  // Software keeps the stack pointer inside high-speed RAM; the low
  // setting lets a push stray below it on purpose to expose the flag
  assign o_sp = i_sp_low ? 16'hFE20 : 16'hFE21;
endmodule

/* sim/test_operand_address_generator.sv */
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("unexpected %s exp=%h got=%h", nm, e, g); \
  end \
end
module test_operand_address_generator;
  import oag_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_valid = 1'b1;
  oag_mode_t i_mode = OAG_MODE_SHORT;
  oag_imp_t i_imp = OAG_IMP_NONE;
  oag_stk_t i_stk = OAG_STK_PUSH;
  logic i_word = 1'b0;
  logic [2:0] i_reg_code = 3'h0;
  logic i_index_c = 1'b0;
  logic [7:0] i_imm8 = 8'h10;
  logic [15:0] i_imm16 = 16'h0000;
  logic i_bank_select_lo = 1'b0;
  logic i_bank_select_hi = 1'b0;
  logic sp_low = 1'b0;
  logic [7:0] i_reg_b, i_reg_c;
  logic [15:0] i_pair_de, i_pair_hl, i_sp;
  logic o_reg_valid, o_reg_dst_word, o_mem_valid, o_mem_hsram;
  logic o_mem_sfr, o_mem_stack, o_addr_fault;
  logic [4:0] o_reg_src, o_reg_dst;
  logic [15:0] o_mem_addr;
  int fails = 0;
  int check_count = 0;

  oag_regfile_model u_model (.i_bank_lo(i_bank_select_lo), .i_sp_low(sp_low),
    .i_bank_hi(i_bank_select_hi), .o_reg_b(i_reg_b), .o_reg_c(i_reg_c),
    .o_pair_de(i_pair_de), .o_pair_hl(i_pair_hl), .o_sp(i_sp));
  oag_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
    .i_mode(i_mode), .i_imp(i_imp), .i_stk(i_stk), .i_word(i_word),
    .i_reg_code(i_reg_code), .i_index_c(i_index_c), .i_imm8(i_imm8),
    .i_imm16(i_imm16), .i_bank_select_lo(i_bank_select_lo),
    .i_bank_select_hi(i_bank_select_hi), .i_reg_b(i_reg_b),
    .i_reg_c(i_reg_c), .i_pair_de(i_pair_de), .i_pair_hl(i_pair_hl),
    .i_sp(i_sp), .o_reg_valid(o_reg_valid), .o_reg_src(o_reg_src),
    .o_reg_dst(o_reg_dst), .o_reg_dst_word(o_reg_dst_word),
    .o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr),
    .o_mem_hsram(o_mem_hsram), .o_mem_sfr(o_mem_sfr),
    .o_mem_stack(o_mem_stack), .o_addr_fault(o_addr_fault));

  // Clock: 40 ns period
  always #20 i_clk = ~i_clk;

  // One request at the falling edge; answer looked at one cycle later
  task automatic req(input oag_mode_t m, input logic [2:0] code,
                     input logic [7:0] b8, input logic [15:0] b16,
                     input logic [1:0] bank, input logic w);
    i_mode = m;
    i_reg_code = code;
    i_imm8 = b8;
    i_imm16 = b16;
    {i_bank_select_hi, i_bank_select_lo} = bank;
    i_word = w;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // Memory-side comparison shared by the addressing scenarios
  task automatic mchk(input logic [15:0] a, input logic hs,
                      input logic sf);
    `CHK("mem_valid", 1'b1, o_mem_valid)
    `CHK("mem_addr", a, o_mem_addr)
    `CHK("mem_hsram", hs, o_mem_hsram)
    `CHK("mem_sfr", sf, o_mem_sfr)
  endtask

  task automatic t_implied();
    i_imp = OAG_IMP_MUL;
    req(OAG_MODE_IMPLIED, 3'h0, 8'h00, 16'h0000, 2'h2, 1'b0);
    `CHK("mul_src", 5'h11, o_reg_src)
    `CHK("mul_dst", 5'h10, o_reg_dst)
    `CHK("mul_word", 1'b1, o_reg_dst_word)
    `CHK("mul_valid", 1'b1, o_reg_valid)
    i_imp = OAG_IMP_DIV;
    req(OAG_MODE_IMPLIED, 3'h5, 8'h00, 16'h0000, 2'h2, 1'b0);
    `CHK("div_src", 5'h10, o_reg_src)
    `CHK("div_dst", 5'h10, o_reg_dst)
    `CHK("div_word", 1'b1, o_reg_dst_word)
    i_imp = OAG_IMP_ADJ;
    req(OAG_MODE_IMPLIED, 3'h7, 8'h00, 16'h0000, 2'h1, 1'b0);
    `CHK("adj_dst", 5'h09, o_reg_dst)
    `CHK("adj_word", 1'b0, o_reg_dst_word)
    i_imp = OAG_IMP_ROT;
    req(OAG_MODE_IMPLIED, 3'h4, 8'h00, 16'h0000, 2'h3, 1'b0);
    `CHK("rot_src", 5'h19, o_reg_src)
    `CHK("rot_dst", 5'h19, o_reg_dst)
    i_imp = OAG_IMP_NONE;
    req(OAG_MODE_IMPLIED, 3'h1, 8'h00, 16'h0000, 2'h0, 1'b0);
    `CHK("imp_none_valid", 1'b0, o_reg_valid)
    $display("test implied done");
  endtask

  task automatic t_register();
    for (int n = 0; n < 32; n++) begin
      req(OAG_MODE_REG, n[2:0], 8'h00, 16'h0000, n[4:3], 1'b0);
      `CHK("reg_valid", 1'b1, o_reg_valid)
      `CHK("reg_src", n[4:0], o_reg_src)
    end
    for (int n = 0; n < 16; n++) begin
      req(OAG_MODE_REG, {n[1:0], 1'b0}, 8'h00, 16'h0000, n[3:2], 1'b1);
      `CHK("pair_src", {n[3:0], 1'b0}, o_reg_src)
      `CHK("pair_word", 1'b1, o_reg_dst_word)
    end
    $display("test register done");
  endtask

  task automatic t_memory();
    logic [7:0] sb [5];
    sb = '{8'h20, 8'hFF, 8'h00, 8'h1F, 8'h10};
    req(OAG_MODE_DIRECT, 3'h0, 8'h00, 16'hFE00, 2'h0, 1'b0);
    mchk(16'hFE00, 1'b0, 1'b0);
    req(OAG_MODE_DIRECT, 3'h0, 8'h00, 16'hFF05, 2'h0, 1'b0);
    mchk(16'hFF05, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      req(OAG_MODE_SHORT, 3'h0, sb[i], 16'h0000, 2'h0, 1'b0);
      mchk({7'h7F, sb[i] < 8'h20, sb[i]}, sb[i] >= 8'h20,
           sb[i] < 8'h20);
    end
    req(OAG_MODE_SHORT, 3'h0, 8'h21, 16'h0000, 2'h0, 1'b1);
    `CHK("short_odd", 1'b1, o_addr_fault)
    req(OAG_MODE_SHORT, 3'h0, 8'h22, 16'h0000, 2'h0, 1'b1);
    `CHK("short_even", 1'b0, o_addr_fault)
    sb = '{8'h00, 8'hCF, 8'hE0, 8'hFF, 8'h1F};
    for (int i = 0; i < 5; i++) begin
      req(OAG_MODE_SFR, 3'h0, sb[i], 16'h0000, 2'h0, 1'b0);
      mchk({8'hFF, sb[i]}, 1'b0, 1'b1);
    end
    req(OAG_MODE_SFR, 3'h0, 8'hD0, 16'h0000, 2'h0, 1'b0);
    `CHK("sfr_gap", 1'b1, o_addr_fault)
    req(OAG_MODE_SFR, 3'h0, 8'hE1, 16'h0000, 2'h0, 1'b1);
    `CHK("sfr_odd", 1'b1, o_addr_fault)
    $display("test memory done");
  endtask

  task automatic t_pointer();
    logic [15:0] a;
    req(OAG_MODE_REG_IND, 3'h1, 8'h00, 16'h0000, 2'h3, 1'b0);
    mchk(16'h1233, 1'b0, 1'b0);
    req(OAG_MODE_REG_IND, 3'h0, 8'h00, 16'h0000, 2'h3, 1'b0);
    mchk(16'hA003, 1'b0, 1'b0);
    req(OAG_MODE_BASED, 3'h0, 8'h20, 16'h0000, 2'h0, 1'b0);
    mchk(16'h0010, 1'b0, 1'b0);
    req(OAG_MODE_BASED, 3'h0, 8'hFF, 16'h0000, 2'h3, 1'b0);
    mchk(16'h1332, 1'b0, 1'b0);
    i_index_c = 1'b1;
    req(OAG_MODE_BASED_IX, 3'h0, 8'h00, 16'h0000, 2'h0, 1'b0);
    mchk(16'h0030, 1'b0, 1'b0);
    i_index_c = 1'b0;
    req(OAG_MODE_BASED_IX, 3'h0, 8'h00, 16'h0000, 2'h1, 1'b0);
    mchk(16'h1252, 1'b0, 1'b0);
    for (int k = 0; k <= 4; k++) begin
      i_stk = oag_stk_t'(k);
      req(OAG_MODE_STACK, 3'h0, 8'h00, 16'h0000, 2'h0, 1'b0);
      a = (k == 1 || k == 3) ? 16'hFE21 : 16'hFE20;
      mchk(a, 1'b1, 1'b0);
      `CHK("stack", 1'b1, o_mem_stack)
      `CHK("fault", 1'b0, o_addr_fault)
    end
    // Stray stack pointer: push lands below the RAM and must be flagged
    sp_low = 1'b1;
    i_stk = OAG_STK_PUSH;
    req(OAG_MODE_STACK, 3'h0, 8'h00, 16'h0000, 2'h0, 1'b0);
    `CHK("stray_addr", 16'hFE1F, o_mem_addr)
    `CHK("stray_fault", 1'b1, o_addr_fault)
    `CHK("stray_hsram", 1'b0, o_mem_hsram)
    i_stk = OAG_STK_POP;
    req(OAG_MODE_STACK, 3'h0, 8'h00, 16'h0000, 2'h0, 1'b0);
    `CHK("low_pop_fault", 1'b0, o_addr_fault)
    sp_low = 1'b0;
    $display("test pointer done");
  endtask

  // Verdict and end of run, also reached by the watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset for 5 cycles, then scenarios back to back
  initial begin
    repeat (5) @(negedge i_clk);
    `CHK("rst_mem_valid", 1'b0, o_mem_valid)
    `CHK("rst_reg_valid", 1'b0, o_reg_valid)
    i_nrst = 1'b1;
    i_valid = 1'b0;
    req(OAG_MODE_SHORT, 3'h0, 8'h10, 16'h0000, 2'h0, 1'b0);
    `CHK("idle_mem_valid", 1'b0, o_mem_valid)
    i_valid = 1'b1;
    t_implied();
    t_register();
    t_memory();
    t_pointer();
    summarize();
  end

  // Watchdog well beyond the fewer than a hundred cycles the scenarios take
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    summarize();
  end
endmodule
